/* shared/sef_defs.vh */
`ifndef SEF_DEFS_VH
`define SEF_DEFS_VH
// Register width of the operation status set
`define SEF_WIDTH 16
// Error queue entry width and depth
`define SEF_ERR_W 16
`define SEF_ERR_DEPTH 8
`define SEF_ERR_PTR_W 3
// Value answered by an empty error queue (no error)
`define SEF_ERR_NONE 16'h0000
// Filter reset values after preset
`define SEF_PTR_PRESET_BIT 1'b1
`define SEF_NTR_PRESET_BIT 1'b0
`endif

/* rtl/sef_error_queue.v */
`timescale 1ns/1ps
`include "sef_defs.vh"
// Error/event queue: pushed by device logic, popped by the error query
module sef_error_queue #(
  parameter W = `SEF_ERR_W,
  parameter DEPTH = `SEF_ERR_DEPTH,
  parameter PW = `SEF_ERR_PTR_W
) (
  input wire clk_in,
  input wire clr_in,
  input wire push_in,
  input wire [W-1:0] push_data_in,
  input wire pop_in,
  output reg [W-1:0] pop_data_out,
  output reg pop_valid_out,
  output reg [PW:0] count_out
);
  // Entry storage
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [PW-1:0] wr_ptr_r;
  reg [PW-1:0] rd_ptr_r;
  wire full = (count_out == DEPTH[PW:0]);
  wire empty = (count_out == {(PW+1){1'b0}});
  wire do_pop = pop_in && !empty;
  // Push drops when full unless a pop frees a slot in the same cycle; the oldest entries are kept
  wire do_push = push_in && (!full || do_pop);
  // Pointer and count update; clear empties the queue
  always @(posedge clk_in) begin
    if (clr_in) begin
      wr_ptr_r <= {PW{1'b0}};
      rd_ptr_r <= {PW{1'b0}};
      count_out <= {(PW+1){1'b0}};
      pop_data_out <= `SEF_ERR_NONE;
      pop_valid_out <= 1'b0;
    end else begin
      pop_valid_out <= pop_in;
      if (pop_in) begin
        pop_data_out <= empty ? `SEF_ERR_NONE : mem_r[rd_ptr_r];
      end
      if (do_push) begin
        mem_r[wr_ptr_r] <= push_data_in;
        wr_ptr_r <= wr_ptr_r + {{(PW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + {{(PW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        count_out <= count_out + {{PW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count_out <= count_out - {{PW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sef_error_queue

/* rtl/sef_status_filter.v */
`timescale 1ns/1ps
`include "sef_defs.vh"
module sef_status_filter #(
  parameter W = `SEF_WIDTH,
  parameter EW = `SEF_ERR_W
) (
  // Clock and reset (reset stands for power-on)
  input wire CLK_IN,
  input wire RESET_IN,
  // Live device status, asynchronous to this clock
  input wire [W-1:0] OPER_STATUS_IN,
  // Common commands
  input wire CLEAR_STATUS_IN,
  input wire PRESET_IN,
  input wire LANG_SWITCH_IN,
  // Register writes
  input wire ENABLE_WR_IN,
  input wire PTR_WR_IN,
  input wire NTR_WR_IN,
  input wire [W-1:0] WR_DATA_IN,
  // Queries
  input wire EVENT_RD_IN,
  input wire COND_RD_IN,
  input wire ENABLE_RD_IN,
  input wire PTR_RD_IN,
  input wire NTR_RD_IN,
  input wire QUES_RD_IN,
  // Error queue feed and query
  input wire ERR_PUSH_IN,
  input wire [EW-1:0] ERR_DATA_IN,
  input wire ERR_RD_IN,
  // Query answers
  output reg [W-1:0] RD_DATA_OUT,
  output reg RD_VALID_OUT,
  output wire [EW-1:0] ERR_DATA_OUT,
  output wire ERR_VALID_OUT,
  output wire [`SEF_ERR_PTR_W:0] ERR_COUNT_OUT,
  // Live register views
  output reg [W-1:0] COND_OUT,
  output reg [W-1:0] EVENT_OUT,
  output reg [W-1:0] ENABLE_OUT,
  output reg [W-1:0] PTR_OUT,
  output reg [W-1:0] NTR_OUT,
  // Summary messages
  output reg OPER_SUMMARY_OUT,
  output reg QUES_SUMMARY_OUT
);
  // Two-stage synchroniser for the live status
  reg [W-1:0] sync1_r;
  reg [W-1:0] sync2_r;
  // Events detected this cycle
  wire [W-1:0] rise = sync2_r & ~COND_OUT;
  wire [W-1:0] fall = ~sync2_r & COND_OUT;
  wire [W-1:0] hit = (rise & PTR_OUT) | (fall & NTR_OUT);
  // Event clearing actions
  wire ev_clr = CLEAR_STATUS_IN | LANG_SWITCH_IN | EVENT_RD_IN;
  // Configuration clearing actions
  wire cfg_clr = PRESET_IN | LANG_SWITCH_IN;
  // Next event value, built below
  reg [W-1:0] event_nxt;
  // Constant used by the clearing actions below, except the filter preset values and the error queue clear
  wire [W-1:0] all_zeros = {W{1'b0}};
  // Positive filter written 0, which clears both filters
  wire ptr_zero_wr = PTR_WR_IN & (WR_DATA_IN == all_zeros);
  // Any register query strobe this cycle; the error query is not included
  wire rd_any = EVENT_RD_IN | COND_RD_IN | ENABLE_RD_IN | PTR_RD_IN | NTR_RD_IN | QUES_RD_IN;
  // Error queue empties on power-on, clear-status or mode switch
  wire errq_clr = RESET_IN | CLEAR_STATUS_IN | LANG_SWITCH_IN;
  // Synchroniser; only the second stage reads the first stage
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on clears both stages
      sync1_r <= all_zeros;
      sync2_r <= all_zeros;
    end else begin
      // Sample the pin, then retime once more
      sync1_r <= OPER_STATUS_IN;
      sync2_r <= sync1_r;
    end
  end
  // Condition tracks status every cycle
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on shows no status
      COND_OUT <= all_zeros;
    end else begin
      // One cycle behind the second stage, so hits compare both
      COND_OUT <= sync2_r;
    end
  end
  // Next event value: clear, then new hits set
  always @* begin
    // Any clearing action empties the register first
    event_nxt = ev_clr ? all_zeros : EVENT_OUT;
    // New hits are ORed in after, so they survive a read clear
    event_nxt = event_nxt | hit;
  end
  // Event register and summary
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on clears events and summaries
      EVENT_OUT <= all_zeros;
      OPER_SUMMARY_OUT <= 1'b0;
      QUES_SUMMARY_OUT <= 1'b0;
    end else begin
      EVENT_OUT <= event_nxt;
      // Summary follows the event value just stored
      OPER_SUMMARY_OUT <= |(event_nxt & ENABLE_OUT);
      // Questionable summary never sets
      QUES_SUMMARY_OUT <= 1'b0;
    end
  end
  // Enable register; clear-status leaves it alone
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on clears the mask
      ENABLE_OUT <= all_zeros;
    end else if (cfg_clr) begin
      // Preset and mode switch both clear the mask
      ENABLE_OUT <= all_zeros;
    end else if (ENABLE_WR_IN) begin
      // Writing 0 clears it, same as any write
      ENABLE_OUT <= WR_DATA_IN;
    end
  end
  // Positive filter: preset sets every bit, mode switch clears it
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on leaves no rising edge selected
      PTR_OUT <= all_zeros;
    end else if (LANG_SWITCH_IN) begin
      // Mode switch wins over a same-cycle preset
      PTR_OUT <= all_zeros;
    end else if (PRESET_IN) begin
      // Preset selects every rising edge
      PTR_OUT <= {W{`SEF_PTR_PRESET_BIT}};
    end else if (PTR_WR_IN) begin
      // A zero write also clears the negative filter below
      PTR_OUT <= WR_DATA_IN;
    end
  end
  // Negative filter: cleared with the positive filter, else written
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on leaves no falling edge selected
      NTR_OUT <= all_zeros;
    end else if (LANG_SWITCH_IN) begin
      // Mode switch clears the filter
      NTR_OUT <= all_zeros;
    end else if (PRESET_IN) begin
      // Preset deselects every falling edge
      NTR_OUT <= {W{`SEF_NTR_PRESET_BIT}};
    end else if (ptr_zero_wr) begin
      // Positive filter written 0 clears the whole filter
      NTR_OUT <= all_zeros;
    end else if (NTR_WR_IN) begin
      // Plain write of the falling-edge selection
      NTR_OUT <= WR_DATA_IN;
    end
  end
  // Query answers, one cycle after the request
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      // Power-on leaves no answer pending
      RD_DATA_OUT <= all_zeros;
      RD_VALID_OUT <= 1'b0;
    end else begin
      // Valid pulses once per query; data holds until the next one
      RD_VALID_OUT <= rd_any;
      // One query at a time is expected; the event query wins
      if (EVENT_RD_IN) begin
        // Old value goes out while the register clears
        RD_DATA_OUT <= EVENT_OUT;
      end else if (COND_RD_IN) begin
        // Condition as it stands now
        RD_DATA_OUT <= COND_OUT;
      end else if (ENABLE_RD_IN) begin
        RD_DATA_OUT <= ENABLE_OUT;
      end else if (PTR_RD_IN) begin
        RD_DATA_OUT <= PTR_OUT;
      end else if (NTR_RD_IN) begin
        RD_DATA_OUT <= NTR_OUT;
      end else if (QUES_RD_IN) begin
        // Questionable set carries no status
        RD_DATA_OUT <= all_zeros;
      end
    end
  end
  // Error queue; pop on query, emptied by errq_clr
  // Entries pushed while full are dropped unless a query pops in the same cycle; the oldest are kept
  sef_error_queue #(
    .W(EW),
    .DEPTH(`SEF_ERR_DEPTH),
    .PW(`SEF_ERR_PTR_W)
  ) u_errq (
    .clk_in(CLK_IN),
    .clr_in(errq_clr),
    .push_in(ERR_PUSH_IN),
    .push_data_in(ERR_DATA_IN),
    .pop_in(ERR_RD_IN),
    .pop_data_out(ERR_DATA_OUT),
    .pop_valid_out(ERR_VALID_OUT),
    .count_out(ERR_COUNT_OUT)
  );
endmodule // sef_status_filter

/* testbench/sef_ctrl.sv */
`timescale 1ns/1ps
// Remote controller model: issues one command strobe at a time
module sef_ctrl (
  input wire logic clk_in,
  output logic [15:0] d_out,
  output logic [13:0] s_out
);
  // Strobe k with data v for one edge, launched just after an edge
  task automatic cmd(input int k, input logic [15:0] v);
    @(posedge clk_in);
    #1 s_out = 14'h1 << k;
    d_out = v;
    @(posedge clk_in);
    #1 s_out = 14'h0;
  endtask
  // Idle bus at time zero
  initial begin
    s_out = 14'h0;
    d_out = 16'h0;
  end
endmodule // sef_ctrl

/* testbench/sef_asserts.sv */
`timescale 1ns/1ps
// Checker on the top ports
module sef_asserts (
  input wire logic CLK_IN, RESET_IN, CLEAR_STATUS_IN, PRESET_IN, LANG_SWITCH_IN,
  input wire logic ENABLE_WR_IN, PTR_WR_IN, EVENT_RD_IN, RD_VALID_OUT,
  input wire logic OPER_SUMMARY_OUT, QUES_SUMMARY_OUT,
  input wire logic [15:0] WR_DATA_IN, RD_DATA_OUT, EVENT_OUT, ENABLE_OUT, PTR_OUT, NTR_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Preset or mode switch overrides writes
  wire cmd = PRESET_IN | LANG_SWITCH_IN;
  AST_SUM: assert property (!$past(ENABLE_WR_IN | cmd) |->
    OPER_SUMMARY_OUT == |(EVENT_OUT & ENABLE_OUT)) else $error("summary wrong");
  AST_QUES: assert property (!QUES_SUMMARY_OUT) else $error("ques summary set");
  AST_PRE: assert property (PRESET_IN && !LANG_SWITCH_IN |=>
    ENABLE_OUT == 16'h0 && PTR_OUT == 16'hffff && NTR_OUT == 16'h0) else $error("preset");
  AST_LANG: assert property (LANG_SWITCH_IN |=>
    (ENABLE_OUT | PTR_OUT | NTR_OUT) == 16'h0) else $error("mode switch");
  AST_CLS: assert property (CLEAR_STATUS_IN && !ENABLE_WR_IN && !cmd |=>
    $stable(ENABLE_OUT)) else $error("clear touched enable");
  AST_ENW: assert property (ENABLE_WR_IN && !cmd |=>
    ENABLE_OUT == $past(WR_DATA_IN)) else $error("enable write");
  AST_PTR0: assert property (PTR_WR_IN && WR_DATA_IN == 16'h0 && !cmd |=>
    (PTR_OUT | NTR_OUT) == 16'h0) else $error("filter zero");
  AST_RD: assert property (EVENT_RD_IN |=>
    RD_VALID_OUT && RD_DATA_OUT == $past(EVENT_OUT)) else $error("event read");
  AST_STICK: assert property (!(CLEAR_STATUS_IN | EVENT_RD_IN | LANG_SWITCH_IN) |=>
    (EVENT_OUT & $past(EVENT_OUT)) == $past(EVENT_OUT)) else $error("event lost");
endmodule // sef_asserts
bind sef_status_filter sef_asserts i_chk (.CLK_IN, .RESET_IN, .CLEAR_STATUS_IN, .PRESET_IN,
  .LANG_SWITCH_IN, .ENABLE_WR_IN, .PTR_WR_IN, .EVENT_RD_IN, .RD_VALID_OUT, .OPER_SUMMARY_OUT,
  .QUES_SUMMARY_OUT, .WR_DATA_IN, .RD_DATA_OUT, .EVENT_OUT, .ENABLE_OUT, .PTR_OUT, .NTR_OUT);

/* testbench/tb_scpi_status_event_filter.sv */
`timescale 1ns/1ps
module tb_scpi_status_event_filter;
  logic clk = 0, rst = 1, rv, ev_v, osum;
  logic [15:0] st = 0, d, rd, ed, pt, nt, cnd, en, q[$], qe[$];
  logic [13:0] s;
  logic [3:0] ecnt;
  int n_fail = 0, check_count = 0;
  always #5 clk = ~clk;
  sef_ctrl i_ctl (.clk_in(clk), .d_out(d), .s_out(s));
  sef_status_filter i_dut (.CLK_IN(clk), .RESET_IN(rst), .OPER_STATUS_IN(st),
    .CLEAR_STATUS_IN(s[0]), .PRESET_IN(s[1]), .LANG_SWITCH_IN(s[2]), .ENABLE_WR_IN(s[3]),
    .PTR_WR_IN(s[4]), .NTR_WR_IN(s[5]), .WR_DATA_IN(d), .EVENT_RD_IN(s[6]),
    .COND_RD_IN(s[7]), .ENABLE_RD_IN(s[8]), .PTR_RD_IN(s[9]), .NTR_RD_IN(s[10]),
    .QUES_RD_IN(s[11]), .ERR_PUSH_IN(s[13]), .ERR_DATA_IN(d), .ERR_RD_IN(s[12]),
    .RD_DATA_OUT(rd), .RD_VALID_OUT(rv), .ERR_DATA_OUT(ed), .ERR_VALID_OUT(ev_v),
    .ERR_COUNT_OUT(ecnt), .COND_OUT(cnd), .EVENT_OUT(), .ENABLE_OUT(), .PTR_OUT(), .NTR_OUT(),
    .OPER_SUMMARY_OUT(osum), .QUES_SUMMARY_OUT());
  // Compare one value and count it
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Query k, noting the expected answer
  task automatic rdq(input int k, input logic [15:0] e);
    q.push_back(e);
    i_ctl.cmd(k, 16'h0);
  endtask
  // Error query, noting the expected entry
  task automatic eq(input logic [15:0] e);
    qe.push_back(e);
    i_ctl.cmd(12, 16'h0);
  endtask
  // Move live status and check the filtered events
  task automatic setst(input logic [15:0] v);
    logic [15:0] e;
    e = (v & ~st & pt) | (~v & st & nt);
    @(posedge clk);
    #1 st = v;
    repeat (5) @(posedge clk);
    cmp("summary", {15'h0, |(e & en)}, {15'h0, osum});
    cmp("cond", v, cnd);
    rdq(7, v);
    rdq(6, e);
    rdq(6, 16'h0);
  endtask
  // Answer watchers
  always @(posedge clk) if (rv === 1'b1) cmp("rd_data", q.pop_front(), rd);
  always @(posedge clk) if (ev_v === 1'b1) cmp("err_data", qe.pop_front(), ed);
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog, a few times the length of the full run
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    stop_test;
  end
  initial begin
    void'($urandom(11));
    repeat (3) @(posedge clk);
    #1 rst = 0;
    rdq(8, 0); rdq(9, 0); rdq(10, 0); rdq(11, 0);
    i_ctl.cmd(1, 16'h0);
    rdq(9, 16'hffff); rdq(10, 0); rdq(8, 0);
    i_ctl.cmd(3, 16'hffff);
    rdq(8, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      pt = $urandom | 16'h1;
      nt = $urandom | 16'h8000;
      i_ctl.cmd(4, pt);
      i_ctl.cmd(5, nt);
      en = $urandom;
      i_ctl.cmd(3, en);
      rdq(8, en);
      rdq(9, pt); rdq(10, nt);
      setst($urandom);
      setst(16'h0);
    end
    // Read clear and a new rising event land on the same edge
    @(posedge clk);
    #1 st = 16'h00ff;
    @(posedge clk);
    rdq(6, 16'h0);
    rdq(6, 16'h00ff & pt);
    i_ctl.cmd(4, 16'hffff);
    @(posedge clk);
    #1 st = 16'hffff;
    repeat (5) @(posedge clk);
    cmp("summary", {15'h0, |(16'hff00 & en)}, {15'h0, osum});
    i_ctl.cmd(0, 16'h0);
    cmp("summary", 16'h0, {15'h0, osum});
    rdq(6, 0); rdq(8, en);
    i_ctl.cmd(4, 16'h0);
    rdq(10, 0);
    i_ctl.cmd(13, 16'h1234);
    i_ctl.cmd(13, 16'h0042);
    cmp("err_count", 16'h2, {12'h0, ecnt});
    eq(16'h1234); eq(16'h0042); eq(16'h0);
    i_ctl.cmd(13, 16'h0077);
    i_ctl.cmd(0, 16'h0);
    cmp("err_count", 16'h0, {12'h0, ecnt});
    eq(16'h0);
    for (int i = 0; i < 9; i++) i_ctl.cmd(13, {12'h0a0, i[3:0]});
    cmp("err_count", 16'h8, {12'h0, ecnt});
    eq(16'h0a00);
    i_ctl.cmd(2, 16'h0);
    cmp("err_count", 16'h0, {12'h0, ecnt});
    rdq(8, 0); rdq(9, 0);
    repeat (4) @(posedge clk);
    stop_test;
  end
endmodule // tb_scpi_status_event_filter
